// file: rtl/pcp_pkg.sv
`default_nettype none
package pcp_pkg;
  localparam logic [7:0] C_NUL = 8'h00;
  localparam logic [7:0] C_BEL = 8'h07;
  localparam logic [7:0] C_BS = 8'h08;
  localparam logic [7:0] C_HT = 8'h09;
  localparam logic [7:0] C_LF = 8'h0A;
  localparam logic [7:0] C_VT = 8'h0B;
  localparam logic [7:0] C_FF = 8'h0C;
  localparam logic [7:0] C_CR = 8'h0D;
  localparam logic [7:0] C_SO = 8'h0E;
  localparam logic [7:0] C_SI = 8'h0F;
  localparam logic [7:0] C_ESC = 8'h1B;
  localparam logic [7:0] E_HSET = 8'h31;
  localparam logic [7:0] E_HCLR = 8'h32;
  localparam logic [7:0] E_HALL = 8'h45;
  localparam logic [7:0] E_VSET = 8'h05;
  localparam logic [7:0] E_VCLR = 8'h36;
  localparam logic [7:0] E_VALL = 8'h46;
  localparam logic [7:0] E_ELON = 8'h3C;
  localparam logic [7:0] E_ELOF = 8'h3D;
  localparam logic [7:0] E_COMP = 8'h3E;
  localparam logic [7:0] E_NORM = 8'h3F;
  localparam logic [7:0] E_ULON = 8'h61;
  localparam logic [7:0] E_ULOF = 8'h62;
  localparam logic [7:0] E_MRST = 8'h63;
  localparam logic [7:0] PR_LO = 8'h20;
  localparam logic [7:0] PR_HI = 8'h7E;
  localparam int BYTE_W = 8;
  localparam int COLS_DEF = 136;
  localparam int LINES_DEF = 66;
  localparam int FIFO_DEPTH_DEF = 8;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ESC = 6'h02,
    ST_NUL1 = 6'h04,
    ST_NUL2 = 6'h08,
    ST_HMOV = 6'h10,
    ST_VMOV = 6'h20
  } pcp_state_t;
  typedef enum logic [1:0] {
    NC_HALL = 2'h0,
    NC_VALL = 2'h1,
    NC_MRST = 2'h2
  } pcp_nulcmd_t;
endpackage
`default_nettype wire

// file: rtl/pcp_byte_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pcp_byte_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport prod (output data, output valid, input ready);
  modport cons (input data, input valid, output ready);
endinterface
`default_nettype wire

// file: rtl/pcp_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module pcp_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  pcp_byte_if.prod out
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH-1);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q, cnt_d;
  logic room_q;
  wire push = in_valid && room_q;
  wire pop = out.valid && out.ready;
  // room flag is its own flop so in_ready leaves a register untouched
  assign in_ready = room_q;
  assign out.valid = (cnt_q != '0);
  assign out.data = mem_q[rd_q];
  assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      room_q <= 1'b1;
    end else begin
      if (push) begin
        wr_q <= (wr_q == PTR_LAST) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == PTR_LAST) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_d;
      room_q <= (cnt_d != CNT_FULL);
    end
  end
endmodule
`default_nettype wire

// file: rtl/pcp_parser.sv
`timescale 1ns/10ps
`default_nettype none
module pcp_parser #(
  parameter int COLS = pcp_pkg::COLS_DEF,
  parameter int LINES = pcp_pkg::LINES_DEF,
  parameter int FIFO_DEPTH = pcp_pkg::FIFO_DEPTH_DEF
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic seven_bit,
  input wire logic [pcp_pkg::BYTE_W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic print_stb,
  output logic [pcp_pkg::BYTE_W-1:0] print_char,
  output logic alt_set,
  output logic elongated,
  output logic compressed,
  output logic underscore,
  output logic bell,
  output logic paper_step,
  output logic [$clog2(COLS)-1:0] column,
  output logic [$clog2(LINES)-1:0] line,
  output logic busy
);
  import pcp_pkg::*;
  localparam int CW = $clog2(COLS);
  localparam int LW = $clog2(LINES);
  localparam logic [CW-1:0] COL_MAX = CW'(COLS-1);
  localparam logic [CW-1:0] COL_PRE = CW'(COLS-2);
  localparam logic [LW-1:0] LIN_MAX = LW'(LINES-1);

  pcp_byte_if #(.W(BYTE_W)) fb ();

  pcp_fifo #(.W(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_data(in_data),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .out(fb.prod)
  );

  pcp_state_t st_q, st_d;
  pcp_nulcmd_t nul_q, nul_d;
  logic [CW-1:0] col_q, col_d;
  logic [LW-1:0] line_q, line_d;
  logic [COLS-1:0] htab_q, htab_d;
  logic [LINES-1:0] vtab_q, vtab_d;
  logic alt_q, alt_d;
  logic elon_q, elon_d;
  logic comp_q, comp_d;
  logic ul_q, ul_d;
  logic ff_q, ff_d;
  logic stb_q, stb_d;
  logic [BYTE_W-1:0] chr_q, chr_d;
  logic bell_q, bell_d;
  logic step_q, step_d;
  logic busy_q;

  // moves stall the stream; the fifo absorbs the host meanwhile
  wire accepting = (st_q == ST_IDLE) || (st_q == ST_ESC) ||
                   (st_q == ST_NUL1) || (st_q == ST_NUL2);
  assign fb.ready = accepting;
  wire take = fb.valid && accepting;
  // the 7-bit mode drops the top bit some controllers leave undefined
  wire [BYTE_W-1:0] code = seven_bit ? {1'b0, fb.data[BYTE_W-2:0]} : fb.data;
  wire is_print = (code >= PR_LO) && (code <= PR_HI);
  wire col_last = (col_q == COL_MAX);
  wire [CW-1:0] col_nx1 = col_last ? col_q : col_q + 1'b1;
  wire [CW-1:0] col_nx2 = (col_q >= COL_PRE) ? COL_MAX : col_q + CW'(2);
  wire [LW-1:0] line_nx = (line_q == LIN_MAX) ? '0 : line_q + 1'b1;
  wire is_nul = (code == C_NUL);

  always_comb begin
    st_d = st_q;
    nul_d = nul_q;
    col_d = col_q;
    line_d = line_q;
    htab_d = htab_q;
    vtab_d = vtab_q;
    alt_d = alt_q;
    elon_d = elon_q;
    comp_d = comp_q;
    ul_d = ul_q;
    ff_d = ff_q;
    stb_d = 1'b0;
    chr_d = chr_q;
    bell_d = 1'b0;
    step_d = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (take && is_print) begin
          stb_d = 1'b1;
          chr_d = code;
          // a double-width cell takes two columns
          col_d = elon_q ? col_nx2 : col_nx1;
        end else if (take) begin
          case (code)
            C_ESC: st_d = ST_ESC;
            C_BEL: bell_d = 1'b1;
            C_BS: begin
              if (col_q != '0) begin
                col_d = col_q - 1'b1;
              end
            end
            C_HT: begin
              if (!col_last) begin
                st_d = ST_HMOV;
              end
            end
            C_LF: begin
              line_d = line_nx;
              step_d = 1'b1;
            end
            C_VT: begin
              st_d = ST_VMOV;
              ff_d = 1'b0;
            end
            C_FF: begin
              st_d = ST_VMOV;
              ff_d = 1'b1;
            end
            C_CR: col_d = '0;
            C_SO: alt_d = 1'b1;
            C_SI: alt_d = 1'b0;
            default: ;
          endcase
        end
      end
      ST_ESC: begin
        if (take) begin
          // parameter byte is never printed, whatever it is
          st_d = ST_IDLE;
          case (code)
            E_HSET: htab_d[col_q] = 1'b1;
            E_HCLR: htab_d[col_q] = 1'b0;
            E_HALL: begin
              nul_d = NC_HALL;
              st_d = ST_NUL1;
            end
            E_VSET: vtab_d[line_q] = 1'b1;
            E_VCLR: vtab_d[line_q] = 1'b0;
            E_VALL: begin
              nul_d = NC_VALL;
              st_d = ST_NUL1;
            end
            E_ELON: elon_d = 1'b1;
            E_ELOF: elon_d = 1'b0;
            E_COMP: comp_d = 1'b1;
            E_NORM: comp_d = 1'b0;
            E_ULON: ul_d = 1'b1;
            E_ULOF: ul_d = 1'b0;
            E_MRST: begin
              nul_d = NC_MRST;
              st_d = ST_NUL1;
            end
            default: ;
          endcase
        end
      end
      ST_NUL1: begin
        if (take) begin
          // a non-null byte here aborts the whole sequence
          st_d = ST_IDLE;
          if (is_nul) begin
            case (nul_q)
              NC_HALL: htab_d = '0;
              NC_VALL: vtab_d = '0;
              NC_MRST: st_d = ST_NUL2;
              default: ;
            endcase
          end
        end
      end
      ST_NUL2: begin
        if (take) begin
          st_d = ST_IDLE;
          if (is_nul) begin
            col_d = '0;
            line_d = '0;
            htab_d = '0;
            vtab_d = '0;
            alt_d = 1'b0;
            elon_d = 1'b0;
            comp_d = 1'b0;
            ul_d = 1'b0;
          end
        end
      end
      ST_HMOV: begin
        // one column per cycle; stops at a stop or the margin
        col_d = col_nx1;
        if ((col_nx1 == COL_MAX) || htab_q[col_nx1]) begin
          st_d = ST_IDLE;
        end
      end
      ST_VMOV: begin
        // without any stop a vertical tab ends at top of form
        line_d = line_nx;
        step_d = 1'b1;
        if ((line_nx == '0) || (!ff_q && vtab_q[line_nx])) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= ST_IDLE;
      nul_q <= NC_HALL;
      col_q <= '0;
      line_q <= '0;
      htab_q <= '0;
      vtab_q <= '0;
      alt_q <= 1'b0;
      elon_q <= 1'b0;
      comp_q <= 1'b0;
      ul_q <= 1'b0;
      ff_q <= 1'b0;
      stb_q <= 1'b0;
      chr_q <= '0;
      bell_q <= 1'b0;
      step_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      nul_q <= nul_d;
      col_q <= col_d;
      line_q <= line_d;
      htab_q <= htab_d;
      vtab_q <= vtab_d;
      alt_q <= alt_d;
      elon_q <= elon_d;
      comp_q <= comp_d;
      ul_q <= ul_d;
      ff_q <= ff_d;
      stb_q <= stb_d;
      chr_q <= chr_d;
      bell_q <= bell_d;
      step_q <= step_d;
      busy_q <= (st_d != ST_IDLE);
    end
  end

  assign print_stb = stb_q;
  assign print_char = chr_q;
  assign alt_set = alt_q;
  assign elongated = elon_q;
  assign compressed = comp_q;
  assign underscore = ul_q;
  assign bell = bell_q;
  assign paper_step = step_q;
  assign column = col_q;
  assign line = line_q;
  assign busy = busy_q;
endmodule
`default_nettype wire

// file: rtl/pcp_end.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// file: bench/pcp_host.sv
`timescale 1ns/10ps
`default_nettype none
module pcp_host (
  input wire logic clk,
  input wire logic rstn,
  output logic [7:0] in_data,
  output logic in_valid,
  input wire logic in_ready
);
  logic [7:0] q[$];
  logic slow = 1'b0;
  logic go;
  initial {in_valid, in_data} = 9'h000;
  task push(input logic [7:0] b);
    q.push_back(b);
  endtask
  // bytes leave strictly in order and are held until taken
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      in_valid <= 1'b0;
      in_data <= 8'h00;
    end else if (!in_valid || in_ready) begin
      if (in_valid) void'(q.pop_front());
      // slow mode leaves a gap cycle after every taken byte
      go = q.size() != 0 && !(slow && in_valid);
      in_valid <= go;
      // released data toggles so a stale byte is never mistaken for a new one
      in_data <= go ? q[0] : ~in_data;
    end
  end
endmodule
`default_nettype wire

// file: bench/pcp_parser_sva.sv
`timescale 1ns/10ps
`default_nettype none
module pcp_parser_sva #(
  parameter int COLS = 136,
  parameter int LINES = 66
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic busy,
  input wire logic print_stb,
  input wire logic [pcp_pkg::BYTE_W-1:0] print_char,
  input wire logic elongated,
  input wire logic compressed,
  input wire logic underscore,
  input wire logic bell,
  input wire logic paper_step,
  input wire logic [$clog2(COLS)-1:0] column,
  input wire logic [$clog2(LINES)-1:0] line
);
  import pcp_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_mode_chg;
    $changed({elongated, compressed, underscore});
  endsequence
  sequence s_line_next;
    line == (($past(line) == LINES - 1) ? '0 : $past(line) + 1'b1);
  endsequence
  print_range_a: assert property (print_stb |-> print_char >= PR_LO && print_char <= PR_HI)
    else $error("printed code outside printable range");
  print_col_a: assert property (print_stb && !elongated && $past(column) < COLS - 1
    |-> column == $past(column) + 1'b1) else $error("column not advanced by one");
  print_wide_a: assert property (print_stb && elongated && $past(column) < COLS - 2
    |-> column == $past(column) + 2'd2) else $error("wide print not advanced by two");
  bell_alone_a: assert property (bell |-> !print_stb && !paper_step)
    else $error("bell together with another action");
  step_line_a: assert property (paper_step |-> s_line_next)
    else $error("paper step without line advance");
  mode_busy_a: assert property (s_mode_chg |-> $past(busy))
    else $error("print mode changed outside an escape");
  col_back_a: assert property (column < $past(column)
    |-> column == 0 || column == $past(column) - 1'b1) else $error("bad column retreat");
  line_move_a: assert property ($changed(line) |-> paper_step || line == 0)
    else $error("line moved without a paper step");
endmodule
`default_nettype wire

// file: bench/pcp_parser_tb.sv
`timescale 1ns/10ps
`default_nettype none
module pcp_parser_tb;
  import pcp_pkg::*;
  logic clk, rstn, seven_bit, in_valid, in_ready, print_stb, alt_set, elongated;
  logic compressed, underscore, bell, paper_step, busy;
  logic [7:0] in_data, print_char, column;
  logic [6:0] line;
  int miscompares = 0, checks = 0, cyc = 0, n_pr = 0, n_bel = 0, n_stp = 0;
  pcp_parser u_pcp_parser (.clk(clk), .rstn(rstn), .seven_bit(seven_bit), .in_data(in_data),
    .in_valid(in_valid), .in_ready(in_ready), .print_stb(print_stb), .print_char(print_char),
    .alt_set(alt_set), .elongated(elongated), .compressed(compressed),
    .underscore(underscore), .bell(bell), .paper_step(paper_step), .column(column),
    .line(line), .busy(busy));
  pcp_host u_pcp_host (.clk(clk), .rstn(rstn), .in_data(in_data), .in_valid(in_valid),
    .in_ready(in_ready));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (print_stb === 1'b1) n_pr <= n_pr + 1;
    if (bell === 1'b1) n_bel <= n_bel + 1;
    if (paper_step === 1'b1) n_stp <= n_stp + 1;
    if (cyc == 8000) begin
      miscompares++;
      results();
    end
  end
  task results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // waits for a quiet spell, since a tab move may start from bytes still queued
  task settle;
    int k;
    int qt;
    k = 0;
    qt = 0;
    while (qt < 12 && k < 600) begin
      @(posedge clk);
      k++;
      qt = (u_pcp_host.q.size() == 0 && in_valid === 1'b0 && busy === 1'b0) ? qt + 1 : 0;
    end
    #1;
  endtask
  task tx(input logic [7:0] b[]);
    @(negedge clk);
    foreach (b[i]) u_pcp_host.push(b[i]);
    settle();
  endtask
  task m(input logic [7:0] b[], input logic [3:0] e);
    tx(b);
    chk({4'h0, alt_set, elongated, compressed, underscore}, {4'h0, e});
  endtask
  task t_print;
    int n;
    n = n_pr;
    u_pcp_host.slow = 1'b1;
    tx('{8'h0D, 8'h20, 8'h7E, 8'h7F, 8'h1F, 8'h41});
    u_pcp_host.slow = 1'b0;
    chk(8'(n_pr - n), 8'h03);
    chk(print_char, 8'h41);
    chk(column, 8'h03);
  endtask
  task t_ctrl;
    int n;
    n = n_bel;
    tx('{8'h08});
    chk(column, 8'h02);
    tx('{8'h0D, 8'h08});
    chk(column, 8'h00);
    tx('{8'h07});
    chk(8'(n_bel - n), 8'h01);
    n = n_stp;
    tx('{8'h0A});
    chk({1'b0, line}, 8'h01);
    tx('{8'h0C});
    chk({1'b0, line}, 8'h00);
    chk(8'(n_stp - n), 8'h42);
  endtask
  task t_modes;
    m('{8'h0E}, 4'h8);
    m('{8'h1B, 8'h3C}, 4'hC);
    tx('{8'h0D, 8'h41});
    chk(column, 8'h02);
    m('{8'h1B, 8'h3E}, 4'hE);
    m('{8'h1B, 8'h61}, 4'hF);
    m('{8'h0F}, 4'h7);
    m('{8'h1B, 8'h3D}, 4'h3);
    m('{8'h1B, 8'h3F}, 4'h1);
    m('{8'h1B, 8'h62}, 4'h0);
  endtask
  task t_htab;
    tx('{8'h0D, 8'h41, 8'h41, 8'h41, 8'h41, 8'h41, 8'h1B, 8'h31, 8'h0D, 8'h09});
    chk(column, 8'h05);
    tx('{8'h1B, 8'h32, 8'h0D, 8'h09});
    chk(column, 8'h87);
    tx('{8'h0D, 8'h41, 8'h41, 8'h41, 8'h41, 8'h41, 8'h1B, 8'h31});
    tx('{8'h1B, 8'h45, 8'h00, 8'h0D, 8'h09});
    chk(column, 8'h87);
  endtask
  task t_vtab;
    tx('{8'h0A, 8'h0A, 8'h0A, 8'h1B, 8'h05, 8'h0C, 8'h0B});
    chk({1'b0, line}, 8'h03);
    tx('{8'h1B, 8'h36, 8'h0B});
    chk({1'b0, line}, 8'h00);
    tx('{8'h0A, 8'h0A, 8'h1B, 8'h05, 8'h1B, 8'h46, 8'h00, 8'h0C, 8'h0B});
    chk({1'b0, line}, 8'h00);
  endtask
  task t_mrst;
    tx('{8'h0E, 8'h1B, 8'h3C, 8'h1B, 8'h3E, 8'h1B, 8'h61});
    m('{8'h0A, 8'h41, 8'h1B, 8'h31}, 4'hF);
    m('{8'h1B, 8'h63, 8'h00, 8'h00}, 4'h0);
    chk(column, 8'h00);
    chk({1'b0, line}, 8'h00);
    tx('{8'h09});
    chk(column, 8'h87);
  endtask
  task t_odd;
    int n;
    n = n_pr;
    tx('{8'h1B, 8'h7A, 8'h1B, 8'h41, 8'h42});
    chk(8'(n_pr - n), 8'h01);
    chk(print_char, 8'h42);
    @(posedge clk);
    seven_bit <= 1'b1;
    tx('{8'hC3});
    chk(print_char, 8'h43);
    @(posedge clk);
    seven_bit <= 1'b0;
    tx('{8'hC4});
    chk(8'(n_pr - n), 8'h02);
  endtask
  task t_fifo;
    int n;
    logic full;
    n = n_pr;
    full = 1'b0;
    @(negedge clk);
    u_pcp_host.push(8'h0D);
    u_pcp_host.push(8'h09);
    repeat (12) u_pcp_host.push(8'h41);
    repeat (60) begin
      @(posedge clk);
      if (in_ready === 1'b0) full = 1'b1;
    end
    settle();
    chk({7'h00, full}, 8'h01);
    chk(8'(n_pr - n), 8'h0C);
  endtask
  initial begin
    rstn = 1'b0;
    seven_bit = 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    chk({busy, print_stb, bell, paper_step, alt_set, elongated, compressed, underscore},
      8'h00);
    chk({in_ready, column[6:0]}, 8'h80);
    t_print();
    t_ctrl();
    t_modes();
    t_htab();
    t_vtab();
    t_mrst();
    t_odd();
    t_fifo();
    results();
  end
endmodule
bind pcp_parser pcp_parser_sva #(.COLS(COLS), .LINES(LINES)) u_pcp_parser_sva (.clk(clk),
  .rstn(rstn), .busy(busy), .print_stb(print_stb), .print_char(print_char),
  .elongated(elongated), .compressed(compressed), .underscore(underscore), .bell(bell),
  .paper_step(paper_step), .column(column), .line(line));
`default_nettype wire
